/* hw/gtc_pkg.sv */
// package of constants and types for the 16-bit timer/counter
package gtc_pkg;
	localparam int          GTC_CNT_W      = 16;
	localparam int          GTC_ADDR_W     = 8;
	// register byte offsets
	localparam logic [7:0]  GTC_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  GTC_OFS_COUNT  = 8'h04;
	localparam logic [7:0]  GTC_OFS_PERIOD = 8'h08;
	localparam logic [7:0]  GTC_OFS_STATUS = 8'h0C;
	localparam logic [7:0]  GTC_OFS_CLEAR  = 8'h10;
	localparam logic [7:0]  GTC_OFS_IRQEN  = 8'h14;
	// timer_control field positions
	localparam int          GTC_BIT_RUN    = 15;
	localparam int          GTC_BIT_IDLE   = 13;
	localparam int          GTC_BIT_GATE   = 6;
	localparam int          GTC_BIT_PSHI   = 5;
	localparam int          GTC_BIT_PSLO   = 4;
	localparam int          GTC_BIT_SYNC   = 2;
	localparam int          GTC_BIT_SRC    = 1;
	localparam logic [15:0] GTC_CTRL_MASK  = 16'hA076;
	localparam logic [15:0] GTC_CTRL_RST   = 16'h0000;
	localparam logic [15:0] GTC_COUNT_RST  = 16'h0000;
	localparam logic [15:0] GTC_PERIOD_RST = 16'hFFFF;
	// status bit: period match
	localparam int          GTC_STAT_W     = 1;
	localparam int          GTC_STAT_MATCH = 0;
	// prescale terminal counts (ratio minus one)
	localparam int          GTC_PS_W       = 8;
	localparam logic [7:0]  GTC_PS_DIV1    = 8'h00;
	localparam logic [7:0]  GTC_PS_DIV8    = 8'h07;
	localparam logic [7:0]  GTC_PS_DIV64   = 8'h3F;
	localparam logic [7:0]  GTC_PS_DIV256  = 8'hFF;

	typedef enum logic [3:0] {
		GTC_MODE_TIMER = 4'b0001,
		GTC_MODE_GATED = 4'b0010,
		GTC_MODE_SYNC  = 4'b0100,
		GTC_MODE_ASYNC = 4'b1000
	} gtc_mode_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} gtc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} gtc_apb_rsp_t;
endpackage

/* hw/gtc_timer.sv */
// 16-bit timer/counter with apb registers and interrupt
`timescale 1ns/100ps
// What this block does
// - sixteen-bit up-counter, timer or event counter
// - asynchronous mode counts straight from input edges
// - synchroniser sits after the prescaler
// - source, gate and sync bits pick mode
// - timer modes count the instruction cycle clock
// - counter modes count external input edges
// - bit 13 halts counting during idle
// - bit 6 gates accumulation, internal source only
// - bits 5-4 pick divide by 1/8/64/256
// - unimplemented control bits read zero
module gtc_timer
	import gtc_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clkEn,
	input  wire logic         idleMode,
	input  wire logic         extCountInput,
	input  wire gtc_apb_req_t apbReq,
	output gtc_apb_rsp_t      apbRsp,
	output logic              irq
);
	logic [15:0]           timerControl;
	logic [15:0]           count;
	logic [15:0]           period;
	logic [GTC_STAT_W-1:0] status;
	logic [GTC_STAT_W-1:0] irqEnable;
	logic [GTC_PS_W-1:0]   psCount;
	logic                  psToggle;
	logic                  syncStage1;
	logic                  syncStage2;
	logic                  syncStage3;
	logic                  asyncDly;
	logic                  extPrev;
	gtc_mode_t             mode;
	logic                  srcEvent;
	logic                  gateOpen;
	logic                  psTerminal;
	logic [GTC_PS_W-1:0]   psLimit;
	logic                  tick;
	logic                  running;
	logic                  matchHit;
	logic                  busWrite;
	logic                  busRead;
	logic [31:0]           readData;
	logic                  addrHit;
	logic                  ctrlWr;
	logic                  countWr;
	logic                  periodWr;
	logic                  clearWr;
	logic                  irqenWr;
	logic                  busAccess;
	logic                  runBit;
	logic                  idleHalt;
	logic                  extRise;
	logic                  psAdvance;
	logic [15:0]           next_count;
	logic [GTC_STAT_W-1:0] next_status;

	function automatic gtc_mode_t decodeMode(input logic [15:0] ctl);
		if (!ctl[GTC_BIT_SRC]) begin
			decodeMode = ctl[GTC_BIT_GATE] ? GTC_MODE_GATED : GTC_MODE_TIMER;
		end else begin
			decodeMode = ctl[GTC_BIT_SYNC] ? GTC_MODE_SYNC : GTC_MODE_ASYNC;
		end
	endfunction

	// one register's write strobe, taken in the pready cycle
	function automatic logic regWrite(input logic wr, input logic [7:0] addr,
		input logic [7:0] ofs);
		regWrite = wr && (addr == ofs);
	endfunction

	// mode and source selection
	always_comb begin
		mode     = decodeMode(timerControl);
		srcEvent = 1'b0;
		gateOpen = 1'b1;
		unique case (mode)
			GTC_MODE_TIMER: begin
				srcEvent = 1'b1;
			end
			GTC_MODE_GATED: begin
				srcEvent = 1'b1;
				gateOpen = extCountInput;
			end
			GTC_MODE_SYNC, GTC_MODE_ASYNC: begin
				srcEvent = extRise;
			end
		endcase
	end

	// prescale ratio
	always_comb begin
		unique case (timerControl[GTC_BIT_PSHI:GTC_BIT_PSLO])
			2'b11:   psLimit = GTC_PS_DIV256;
			2'b10:   psLimit = GTC_PS_DIV64;
			2'b01:   psLimit = GTC_PS_DIV8;
			default: psLimit = GTC_PS_DIV1;
		endcase
	end

	// run qualifiers and prescaler advance
	assign runBit     = timerControl[GTC_BIT_RUN];
	assign idleHalt   = idleMode && timerControl[GTC_BIT_IDLE];
	assign running    = runBit && !idleHalt;
	assign extRise    = extCountInput && !extPrev;
	assign psAdvance  = running && srcEvent && gateOpen;
	assign psTerminal = (psCount == psLimit);
	assign matchHit   = tick && (count == period);

	// count-clock tick: synchronised or direct prescaler output
	always_comb begin
		tick = psToggle ^ asyncDly;
		unique case (mode)
			GTC_MODE_SYNC: begin
				tick = syncStage2 ^ syncStage3;
			end
			GTC_MODE_TIMER, GTC_MODE_GATED, GTC_MODE_ASYNC: begin
				tick = psToggle ^ asyncDly;
			end
		endcase
	end

	// edge detect on the pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			extPrev <= 1'b0;
		end else if (clkEn) begin
			extPrev <= extCountInput;
		end
	end

	// prescaler event count, cleared while stopped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			psCount <= GTC_PS_DIV1;
		end else if (clkEn) begin
			if (!running) begin
				psCount <= GTC_PS_DIV1;
			end else if (psAdvance && psTerminal) begin
				psCount <= GTC_PS_DIV1;
			end else if (psAdvance) begin
				psCount <= psCount + 8'h01;
			end
		end
	end

	// prescaler output, one toggle per terminal count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			psToggle <= 1'b0;
		end else if (clkEn && psAdvance && psTerminal) begin
			psToggle <= ~psToggle;
		end
	end

	// synchroniser after the prescaler, plus an edge flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncStage1 <= 1'b0;
			syncStage2 <= 1'b0;
			syncStage3 <= 1'b0;
		end else if (clkEn) begin
			syncStage1 <= psToggle;
			syncStage2 <= syncStage1;
			syncStage3 <= syncStage2;
		end
	end

	// direct path: one flop turns the toggle into a tick
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			asyncDly <= 1'b0;
		end else if (clkEn) begin
			asyncDly <= psToggle;
		end
	end

	// apb decode
	assign busAccess = apbReq.psel && apbReq.penable && !apbRsp.pready;
	assign busWrite  = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
	assign busRead   = busAccess && !apbReq.pwrite;

	// per-register write strobes
	assign ctrlWr    = regWrite(busWrite, apbReq.paddr, GTC_OFS_CTRL);
	assign countWr   = regWrite(busWrite, apbReq.paddr, GTC_OFS_COUNT);
	assign periodWr  = regWrite(busWrite, apbReq.paddr, GTC_OFS_PERIOD);
	assign clearWr   = regWrite(busWrite, apbReq.paddr, GTC_OFS_CLEAR);
	assign irqenWr   = regWrite(busWrite, apbReq.paddr, GTC_OFS_IRQEN);

	always_comb begin
		readData = 32'h0000_0000;
		addrHit  = 1'b1;
		unique case (apbReq.paddr)
			GTC_OFS_CTRL:   readData[15:0] = timerControl & GTC_CTRL_MASK;
			GTC_OFS_COUNT:  readData[15:0] = count;
			GTC_OFS_PERIOD: readData[15:0] = period;
			GTC_OFS_STATUS: readData[GTC_STAT_W-1:0] = status;
			GTC_OFS_CLEAR:  readData = 32'h0000_0000;
			GTC_OFS_IRQEN:  readData[GTC_STAT_W-1:0] = irqEnable;
			default:        addrHit = 1'b0;
		endcase
	end

	// apb response: one wait state, then pready for one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			apbRsp <= '0;
		end else if (clkEn) begin
			if (busAccess) begin
				apbRsp.pready  <= 1'b1;
				apbRsp.pslverr <= !addrHit;
				apbRsp.prdata  <= busRead ? readData : 32'h0000_0000;
			end else begin
				apbRsp <= '0;
			end
		end
	end

	// control register, unimplemented bits kept at zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timerControl <= GTC_CTRL_RST;
		end else if (clkEn && ctrlWr) begin
			timerControl <= apbReq.pwdata[15:0] & GTC_CTRL_MASK;
		end
	end

	// period register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			period <= GTC_PERIOD_RST;
		end else if (clkEn && periodWr) begin
			period <= apbReq.pwdata[15:0];
		end
	end

	// interrupt enable register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqEnable <= '0;
		end else if (clkEn && irqenWr) begin
			irqEnable <= apbReq.pwdata[GTC_STAT_W-1:0];
		end
	end

	// next counter value: bus write beats match, match beats tick
	always_comb begin
		next_count = count;
		if (countWr) begin
			next_count = apbReq.pwdata[15:0];
		end else if (matchHit) begin
			next_count = GTC_COUNT_RST;
		end else if (tick) begin
			next_count = count + 16'h0001;
		end
	end

	// the counter itself
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= GTC_COUNT_RST;
		end else if (clkEn) begin
			count <= next_count;
		end
	end

	// sticky status, set wins over clear
	always_comb begin
		next_status = status;
		if (clearWr) begin
			next_status = status & ~apbReq.pwdata[GTC_STAT_W-1:0];
		end
		if (matchHit) begin
			next_status[GTC_STAT_MATCH] = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status <= '0;
		end else if (clkEn) begin
			status <= next_status;
		end
	end

	// interrupt output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (clkEn) begin
			irq <= |(status & irqEnable);
		end
	end
endmodule

/* dv/gtc_timer_assertions.sv */
// port checker for the timer
`timescale 1ns/100ps
module gtc_timer_assertions
	import gtc_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         clkEn,
	input wire logic         idleMode,
	input wire logic         extCountInput,
	input wire gtc_apb_req_t apbReq,
	input wire gtc_apb_rsp_t apbRsp,
	input wire logic         irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_access;
		apbReq.psel && apbReq.penable && !apbRsp.pready && clkEn;
	endsequence
	sequence s_read(logic [7:0] a);
		apbRsp.pready && !apbReq.pwrite && apbReq.paddr == a;
	endsequence
	a_ready_pulse: assert property (apbRsp.pready && clkEn |=> !apbRsp.pready)
		else $error("pready held too long");
	a_ready_wait: assert property (s_access |=> apbRsp.pready)
		else $error("pready late");
	a_ready_cause: assert property ($rose(apbRsp.pready) |-> $past(apbReq.penable))
		else $error("pready without access");
	a_err_unmapped: assert property (apbRsp.pready && apbReq.paddr > GTC_OFS_IRQEN
		|-> apbRsp.pslverr && apbRsp.prdata == 0) else $error("unmapped not refused");
	a_err_mapped: assert property (apbRsp.pready && apbReq.paddr <= GTC_OFS_IRQEN
		&& apbReq.paddr[1:0] == 0 |-> !apbRsp.pslverr) else $error("mapped refused");
	a_ctrl_zeros: assert property (s_read(GTC_OFS_CTRL) |->
		(apbRsp.prdata & ~{16'h0000, GTC_CTRL_MASK}) == 0) else $error("ctrl bits set");
	a_status_width: assert property (s_read(GTC_OFS_STATUS) |->
		apbRsp.prdata[31:1] == 0) else $error("status upper bits set");
	a_irq_fall: assert property ($fell(irq) |->
		$past(apbRsp.pready, 2) && $past(apbReq.pwrite, 2)) else $error("irq fell without write");
endmodule
bind gtc_timer gtc_timer_assertions gtc_timer_assertions_inst (.clk(clk), .rst(rst),
	.clkEn(clkEn), .idleMode(idleMode), .extCountInput(extCountInput),
	.apbReq(apbReq), .apbRsp(apbRsp), .irq(irq));

/* dv/gtc_pin_model.sv */
// external pin: low, high, or rising every four cycles
`timescale 1ns/100ps
module gtc_pin_model (
	input  wire logic       clk,
	input  wire logic [1:0] pinMode,
	output logic            extCountInput
);
	logic [1:0] phase = 2'h0;
	always @(posedge clk) begin
		phase <= phase + 2'h1;
	end
	assign extCountInput = (pinMode == 2'h2) ? phase[1] : pinMode[0];
endmodule

/* dv/gtc_timer_bench.sv */
// self-checking bench for the timer
`timescale 1ns/100ps
module gtc_timer_bench
	import gtc_pkg::*;
;
	logic         clk = 0;
	logic         rst = 1;
	logic         idleMode = 0;
	logic [1:0]   pinMode = 0;
	logic         extCountInput;
	logic         irq;
	logic         err;
	logic [31:0]  rd;
	gtc_apb_req_t apbReq = '0;
	gtc_apb_rsp_t apbRsp;
	int           errTotal = 0;
	int           testsRun = 0;
	int           cyc = 0;
	int           lo;
	int           hi;
	gtc_timer gtc_timer_inst (.clk(clk), .rst(rst), .clkEn(1'b1), .idleMode(idleMode),
		.extCountInput(extCountInput), .apbReq(apbReq), .apbRsp(apbRsp), .irq(irq));
	gtc_pin_model gtc_pin_model_inst (.clk(clk), .pinMode(pinMode),
		.extCountInput(extCountInput));
	always #5 clk = ~clk;
	task results();
		$display("tests %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			errTotal++;
			results();
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		do @(posedge clk); while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			errTotal++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task measure(input logic [15:0] c, input logic idl, input logic [1:0] pm, input int dv);
		idleMode <= idl;
		pinMode <= pm;
		apb(1, GTC_OFS_COUNT, 0);
		apb(1, GTC_OFS_CTRL, {16'h0000, c});
		repeat (1024) @(posedge clk);
		apb(1, GTC_OFS_CTRL, 0);
		apb(0, GTC_OFS_COUNT, 0);
		lo = dv ? 1024 / dv - 2 : 0;
		hi = dv ? 1040 / dv + 2 : 0;
		testsRun++;
		if (((rd[15:0] >= lo) && (rd[15:0] <= hi)) !== 1'b1) begin
			errTotal++;
			$display("unexpected t=%0t got %h exp %h", $time, rd[15:0], lo);
		end
		$display("test ctrl %h done", c);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		apb(0, GTC_OFS_CTRL, 0);
		chk(rd, 0);
		apb(0, GTC_OFS_PERIOD, 0);
		chk(rd, 32'h0000_FFFF);
		apb(1, GTC_OFS_CTRL, 32'hFFFF_FFFF);
		apb(0, GTC_OFS_CTRL, 0);
		chk(rd, 32'h0000_A076);
		$display("test register defaults done");
		measure(16'h0000, 0, 2, 0);
		measure(16'h8000, 0, 0, 1);
		measure(16'h8010, 0, 0, 8);
		measure(16'h8020, 0, 0, 64);
		measure(16'h8030, 0, 0, 256);
		measure(16'h8040, 0, 0, 0);
		measure(16'h8040, 0, 1, 1);
		measure(16'h8006, 0, 2, 4);
		measure(16'h8002, 0, 2, 4);
		measure(16'h8042, 0, 2, 4);
		measure(16'h8016, 0, 2, 32);
		measure(16'hA000, 1, 0, 0);
		measure(16'h8000, 1, 0, 1);
		apb(1, GTC_OFS_PERIOD, 4);
		apb(1, GTC_OFS_COUNT, 0);
		apb(1, GTC_OFS_CTRL, 32'h0000_8000);
		repeat (20) @(posedge clk);
		apb(1, GTC_OFS_CTRL, 0);
		apb(0, GTC_OFS_COUNT, 0);
		chk({31'h0, rd[15:0] <= 16'h0004}, 1);
		apb(0, GTC_OFS_STATUS, 0);
		chk(rd, 1);
		chk({31'h0, irq}, 0);
		apb(1, GTC_OFS_IRQEN, 1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 1);
		apb(1, GTC_OFS_CLEAR, 1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 0);
		apb(0, 8'h40, 0);
		chk({31'h0, err}, 1);
		$display("test irq and refusal done");
		results();
	end
endmodule
